/* File: core/sar_adc_pkg.sv */
// Package with register map, field layout and timing constants of the converter control block.
package sar_adc_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] ADDR_CONVERSION_CONTROL = 8'h1F;
    localparam logic [7:0] ADDR_PIN_CONFIGURATION  = 8'h9F;
    localparam logic [7:0] ADDR_CONVERSION_RESULT  = 8'h1E;
    localparam logic [7:0] ADDR_IRQ_CONTROL        = 8'h0C;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CTRL_CLK_LSB   = 6;
    localparam int CTRL_CHAN_LSB  = 3;
    localparam int CTRL_GO_BIT    = 2;
    localparam int CTRL_ON_BIT    = 0;
    localparam int IRQ_FLAG_BIT   = 0;
    localparam int IRQ_ENABLE_BIT = 1;
    localparam int IRQ_GLOBAL_BIT = 2;

    localparam logic [7:0] CONTROL_RESET  = 8'h00;
    localparam logic [2:0] PORT_CFG_RESET = 3'h0;
    localparam logic [3:0] SPECIAL_EVENT_MODE = 4'hB;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int RESULT_BITS = 8;
    // Conversion is 9.5 bit periods; counted in half bit periods.
    localparam int CONV_HALF_PERIODS = 19;
    localparam int DIV_FOSC2  = 2;
    localparam int DIV_FOSC8  = 8;
    localparam int DIV_FOSC32 = 32;

    typedef enum logic [1:0] {
        CLK_DIV2  = 2'b00,
        CLK_DIV8  = 2'b01,
        CLK_DIV32 = 2'b10,
        CLK_RC    = 2'b11
    } conv_clock_type;

    typedef struct packed {
        conv_clock_type conv_clock_select;
        logic [2:0]     channel_select;
        logic           go_done;
        logic           reserved;
        logic           converter_on;
    } conversion_control_type;

endpackage

/* File: core/sar_adc_control.sv */
// Control logic of the eight-bit four-input successive-approximation converter.
`timescale 1ns/1ps
module sar_adc_control #(
    parameter int RC_HALF_DIV = 200
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    input  wire logic       i_sleep,
    input  wire logic       i_rc_tick,
    input  wire logic [3:0] i_capture_unit_mode,
    input  wire logic       i_special_event,
    input  wire logic       i_comp_high,
    input  wire logic [3:0] i_port_pins,
    output logic      [3:0] o_port_read,
    output logic      [2:0] o_sar_trial,
    output logic      [7:0] o_sar_code,
    output logic      [1:0] o_analog_mux,
    output logic            o_sample_connect,
    output logic            o_analog_power,
    output logic            o_ext_reference,
    output logic      [3:0] o_analog_pins,
    output logic            o_conv_done_irq
);

    sar_adc_pkg::conversion_control_type ctrl;
    logic [2:0]  port_cfg_select;
    logic [7:0]  conversion_result;
    logic [7:0]  sar;
    logic [4:0]  half_count;
    logic [7:0]  div_count;
    logic        conv_done_irq_flag;
    logic        conv_done_irq_enable;
    logic        global_irq_enable;
    logic        half_tick;
    logic        finish;
    logic        start;
    logic [7:0]  half_limit;
    logic [7:0]  ctrl_bits;
    logic        wr_ctrl;

    assign ctrl_bits = ctrl;
    assign wr_ctrl   = i_wr && i_addr == sar_adc_pkg::ADDR_CONVERSION_CONTROL;

    // ************************************************************
    // Conversion clock
    // ************************************************************
    always_comb begin
        unique case (ctrl.conv_clock_select)
            sar_adc_pkg::CLK_DIV2:  half_limit = 8'(sar_adc_pkg::DIV_FOSC2 / 2);
            sar_adc_pkg::CLK_DIV8:  half_limit = 8'(sar_adc_pkg::DIV_FOSC8 / 2);
            sar_adc_pkg::CLK_DIV32: half_limit = 8'(sar_adc_pkg::DIV_FOSC32 / 2);
            sar_adc_pkg::CLK_RC:    half_limit = 8'(RC_HALF_DIV);
        endcase
    end

    // The system clock stops in sleep, so only the RC source advances then.
    always_comb begin
        if (ctrl.conv_clock_select == sar_adc_pkg::CLK_RC) begin
            half_tick = i_rc_tick;
        end else begin
            half_tick = !i_sleep && (div_count == half_limit - 8'h01);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst || !ctrl.go_done || half_tick) begin
            div_count <= 8'h00;
        end else begin
            div_count <= div_count + 8'h01;
        end
    end

    // ************************************************************
    // Start and sequencing
    // ************************************************************
    assign start = ctrl.converter_on && !ctrl.go_done &&
                   ((wr_ctrl && i_wdata[sar_adc_pkg::CTRL_GO_BIT]
                     && i_wdata[sar_adc_pkg::CTRL_ON_BIT]) ||
                    (i_special_event &&
                     i_capture_unit_mode == sar_adc_pkg::SPECIAL_EVENT_MODE));
    assign finish = ctrl.go_done && half_tick &&
                    half_count == 5'(sar_adc_pkg::CONV_HALF_PERIODS - 1);

    always_ff @(posedge i_clk) begin
        if (i_rst || start || !ctrl.go_done) begin
            half_count <= 5'h00;
        end else if (half_tick) begin
            half_count <= half_count + 5'h01;
        end
    end

    // One trial bit per full bit period, decided on odd half periods.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sar <= 8'h00;
        end else if (start) begin
            sar <= 8'h80;
        end else if (ctrl.go_done && half_tick && half_count[0] && half_count < 5'h10) begin
            // The bit under trial keeps the comparator verdict and the next bit is tried.
            sar[o_sar_trial] <= i_comp_high;
            if (o_sar_trial != 3'h0) begin
                sar[o_sar_trial - 3'h1] <= 1'b1;
            end
        end
    end
    assign o_sar_code  = sar;
    assign o_sar_trial = 3'(7 - int'(half_count[4:1]));

    // ************************************************************
    // Control register
    // ************************************************************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ctrl <= sar_adc_pkg::CONTROL_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl.conv_clock_select <= sar_adc_pkg::conv_clock_type'(i_wdata[7:6]);
                ctrl.channel_select    <= i_wdata[5:3];
                ctrl.reserved          <= i_wdata[1];
                ctrl.converter_on      <= i_wdata[sar_adc_pkg::CTRL_ON_BIT];
            end
            if (start) begin
                ctrl.go_done <= 1'b1;
            end else if (finish || (wr_ctrl && !i_wdata[sar_adc_pkg::CTRL_ON_BIT])) begin
                ctrl.go_done <= 1'b0;
            end else if (wr_ctrl && !i_wdata[sar_adc_pkg::CTRL_GO_BIT]) begin
                ctrl.go_done <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            port_cfg_select <= sar_adc_pkg::PORT_CFG_RESET;
        end else if (i_wr && i_addr == sar_adc_pkg::ADDR_PIN_CONFIGURATION) begin
            port_cfg_select <= i_wdata[2:0];
        end
    end

    // No reset here so the last result stays readable after any reset.
    always_ff @(posedge i_clk) begin
        if (finish) begin
            conversion_result <= {sar[7:1], i_comp_high};
        end
    end

    // ************************************************************
    // Interrupt flag and enables
    // ************************************************************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            conv_done_irq_flag   <= 1'b0;
            conv_done_irq_enable <= 1'b0;
            global_irq_enable    <= 1'b0;
        end else begin
            if (i_wr && i_addr == sar_adc_pkg::ADDR_IRQ_CONTROL) begin
                conv_done_irq_enable <= i_wdata[sar_adc_pkg::IRQ_ENABLE_BIT];
                global_irq_enable    <= i_wdata[sar_adc_pkg::IRQ_GLOBAL_BIT];
                conv_done_irq_flag   <= i_wdata[sar_adc_pkg::IRQ_FLAG_BIT];
            end
            if (finish) begin
                conv_done_irq_flag <= 1'b1;
            end
        end
    end
    assign o_conv_done_irq = conv_done_irq_flag && conv_done_irq_enable
                             && global_irq_enable;

    // ************************************************************
    // Pin configuration decode
    // ************************************************************
    always_comb begin
        o_ext_reference = 1'b0;
        o_analog_pins   = 4'hF;
        if (port_cfg_select[2:1] == 2'b11) begin
            o_analog_pins = 4'h0;
        end else begin
            o_ext_reference = port_cfg_select[0];
            if (port_cfg_select[0]) begin
                o_analog_pins[3] = 1'b0;
            end
            if (port_cfg_select[2]) begin
                o_analog_pins[2] = 1'b0;
            end
        end
    end
    assign o_port_read = i_port_pins & ~o_analog_pins;

    assign o_analog_mux     = ctrl.channel_select[1:0];
    assign o_sample_connect = ctrl.converter_on && !ctrl.go_done;
    assign o_analog_power   = ctrl.converter_on;

    // ************************************************************
    // Read port
    // ************************************************************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            unique case (i_addr)
                sar_adc_pkg::ADDR_CONVERSION_CONTROL: o_rdata <= ctrl_bits;
                sar_adc_pkg::ADDR_PIN_CONFIGURATION:  o_rdata <= {5'h00, port_cfg_select};
                sar_adc_pkg::ADDR_CONVERSION_RESULT:  o_rdata <= conversion_result;
                sar_adc_pkg::ADDR_IRQ_CONTROL: o_rdata <= {5'h00, global_irq_enable,
                                                           conv_done_irq_enable,
                                                           conv_done_irq_flag};
                default: o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

endmodule

/* File: testbench/sar_adc_control_sva.sv */
// Assertion checker for the converter control block.
`timescale 1ns/1ps
module sar_adc_control_sva (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    input  wire logic [7:0] o_rdata,
    input  wire logic       i_sleep,
    input  wire logic [3:0] i_capture_unit_mode,
    input  wire logic       i_special_event,
    input  wire logic [3:0] i_port_pins,
    input  wire logic [3:0] o_port_read,
    input  wire logic [1:0] o_analog_mux,
    input  wire logic       o_sample_connect,
    input  wire logic       o_analog_power,
    input  wire logic       o_ext_reference,
    input  wire logic [3:0] o_analog_pins
);
    wire        ctl_wr = i_wr && i_addr == sar_adc_pkg::ADDR_CONVERSION_CONTROL;
    wire        cfg_wr = i_wr && i_addr == sar_adc_pkg::ADDR_PIN_CONFIGURATION;
    logic [1:0] clk_sel;
    logic [2:0] cfg;
    wire        an = ~(cfg[2] & cfg[1]);
    // Shadows of the written fields, since the checker cannot see the registers.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            clk_sel <= 2'h0;
            cfg     <= 3'h0;
        end else begin
            if (ctl_wr) clk_sel <= i_wdata[7:6];
            if (cfg_wr) cfg <= i_wdata[2:0];
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence conv_start;
        $fell(o_sample_connect) && o_analog_power && clk_sel == 2'h0 && !i_sleep;
    endsequence
    sequence conv_run;
        !o_sample_connect [*8] ##[10:13] o_sample_connect;
    endsequence
    conv_len_a: assert property (conv_start |-> conv_run)
        else $error("conversion span wrong");
    cfg_read_a: assert property (i_rd && i_addr == sar_adc_pkg::ADDR_PIN_CONFIGURATION
        |=> o_rdata[7:3] == 5'h00) else $error("upper bits not zero");
    power_on_a: assert property (ctl_wr |=> o_analog_power == $past(i_wdata[0]))
        else $error("power does not follow write");
    chan_route_a: assert property (ctl_wr |=> o_analog_mux == $past(i_wdata[4:3]))
        else $error("channel not routed");
    pins_cfg_a: assert property (o_analog_pins == {an & ~cfg[0], ~cfg[2], an, an})
        else $error("analog pins wrong");
    ext_ref_a: assert property (o_ext_reference == (cfg[0] && an))
        else $error("reference wrong");
    port_read_a: assert property (o_port_read == (i_port_pins & ~o_analog_pins))
        else $error("port read wrong");
    trig_start_a: assert property (i_special_event && o_analog_power && o_sample_connect
        && i_capture_unit_mode == sar_adc_pkg::SPECIAL_EVENT_MODE && !i_wr
        |=> !o_sample_connect) else $error("trigger did not start");
    start_cut_a: assert property (ctl_wr && i_wdata[2] && i_wdata[0] && o_analog_power
        && o_sample_connect |=> !o_sample_connect) else $error("hold not cut");
    reset_state_a: assert property ($fell(i_rst) |-> !o_analog_power && o_rdata == 8'h00)
        else $error("reset state wrong");
endmodule
bind sar_adc_control sar_adc_control_sva chk_u (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .i_sleep, .i_capture_unit_mode, .i_special_event, .i_port_pins,
    .o_port_read, .o_analog_mux, .o_sample_connect, .o_analog_power, .o_ext_reference,
    .o_analog_pins);

/* File: testbench/sar_adc_control_tb.sv */
// Self-checking testbench for the converter control block.
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module sar_adc_control_tb;
    logic       i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_sleep = 1'b0;
    logic       i_rc_tick = 1'b0, i_special_event = 1'b0, i_comp_high = 1'b0;
    logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata, o_sar_code;
    logic [3:0] i_capture_unit_mode = 4'h0, i_port_pins = 4'hF, o_port_read, o_analog_pins;
    logic [2:0] o_sar_trial;
    logic [1:0] o_analog_mux, tick_cnt = 2'h0;
    logic       o_sample_connect, o_analog_power, o_ext_reference, o_conv_done_irq;
    int         fail_count = 0, n_compared = 0, n;
    logic [7:0] d;
    sar_adc_control dut_u (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_sleep, .i_rc_tick, .i_capture_unit_mode, .i_special_event, .i_comp_high,
        .i_port_pins, .o_port_read, .o_sar_trial, .o_sar_code, .o_analog_mux,
        .o_sample_connect, .o_analog_power, .o_ext_reference, .o_analog_pins, .o_conv_done_irq);
    initial forever #5 i_clk = ~i_clk;
    // The RC half bit period is four system cycles, unrelated to any divider.
    always @(posedge i_clk) begin
        tick_cnt <= tick_cnt + 2'h1;
        i_rc_tick <= (tick_cnt == 2'h3);
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge i_clk) begin i_addr <= a; i_wdata <= v; i_wr <= 1'b1; end
        @(posedge i_clk) i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge i_clk) begin i_addr <= a; i_rd <= 1'b1; end
        @(posedge i_clk) i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask
    // Configure, acquire, start, poll, read, then rest before the next acquisition.
    task automatic conv(input logic [1:0] s, input logic [1:0] c, input logic v);
        @(posedge i_clk) i_comp_high <= v;
        wr(8'h1F, {s, 1'b0, c, 3'h1});
        #1 `CHK("mux", c, o_analog_mux)
        repeat (8) @(posedge i_clk);
        wr(8'h1F, {s, 1'b0, c, 3'h5});
        #1 `CHK("hold", 1'b0, o_sample_connect)
        for (n = 0; n < 999 && o_sample_connect !== 1'b1; n++) @(posedge i_clk) #1;
        rd(8'h1E);
        `CHK("result", {8{v}}, d)
        `CHK("sar", {8{v}}, o_sar_code)
        `CHK("trial", 3'h7, o_sar_trial)
        rd(8'h1F);
        `CHK("go", {s, 1'b0, c, 3'h1}, d)
        repeat (64) @(posedge i_clk);
    endtask
    task automatic t_pins;
        logic [2:0] c;
        logic [3:0] p;
        for (int i = 0; i < 8; i++) begin
            c = i[2:0];
            p = {~&c[2:1] & ~c[0], ~c[2], ~&c[2:1], ~&c[2:1]};
            wr(8'h9F, {5'h1F, c});
            rd(8'h9F);
            `CHK("cfg", {5'h00, c}, d)
            `CHK("pins", p, o_analog_pins)
            `CHK("vref", c[0] & ~&c[2:1], o_ext_reference)
            `CHK("port", ~p, o_port_read)
        end
        wr(8'h9F, 8'h00);
    endtask
    task automatic t_clocks;
        int h[4] = '{1, 4, 16, 4};
        for (int s = 0; s < 4; s++) begin
            conv(s[1:0], s[1:0], s[0]);
            // The RC tick phase is free running, so its first half period is 1 to 4 cycles.
            `CHK("span", 1'b1, s == 3 ? (n >= 73 && n <= 76) : n == 19 * h[s])
        end
    endtask
    task automatic t_sleep;
        i_sleep <= 1'b1;
        wr(8'h1F, 8'h49);
        wr(8'h1F, 8'h4D);
        repeat (200) @(posedge i_clk);
        `CHK("stall", 1'b0, o_sample_connect)
        wr(8'h1F, 8'h49);
        conv(2'h3, 2'h0, 1'b1);
        `CHK("rcsleep", 1'b1, n < 80)
        i_sleep <= 1'b0;
    endtask
    task automatic t_irq;
        wr(8'h0C, 8'h06);
        conv(2'h0, 2'h2, 1'b0);
        repeat (10) @(posedge i_clk);
        `CHK("irq", 1'b1, o_conv_done_irq)
        wr(8'h0C, 8'h03);
        #1 `CHK("mask", 1'b0, o_conv_done_irq)
        wr(8'h0C, 8'h07);
        #1 `CHK("sticky", 1'b1, o_conv_done_irq)
        wr(8'h0C, 8'h06);
        #1 `CHK("clear", 1'b0, o_conv_done_irq)
    endtask
    task automatic t_trig;
        i_capture_unit_mode <= 4'hB;
        i_comp_high <= 1'b1;
        wr(8'h1F, 8'hC1);
        for (int on = 1; on >= 0; on--) begin
            wr(8'h1F, {7'h60, on[0]});
            @(posedge i_clk) i_special_event <= 1'b1;
            @(posedge i_clk) i_special_event <= 1'b0;
            rd(8'h1F);
            `CHK("trig", {5'h18, on[0], 1'b0, on[0]}, d)
            repeat (90) @(posedge i_clk);
        end
    endtask
    task automatic t_rst;
        wr(8'h1F, 8'h81);
        wr(8'h1F, 8'h85);
        repeat (50) @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(8'h1F);
        `CHK("ctlrst", 8'h00, d)
        rd(8'h1E);
        `CHK("keep", 8'hFF, d)
    endtask
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        #100000;
        fail_count++;
        results();
    end
    initial begin
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(8'h1F);
        `CHK("ctl0", 8'h00, d)
        rd(8'h55);
        `CHK("unmapped", 8'h00, d)
        `CHK("off", 1'b0, o_analog_power)
        t_pins();
        t_clocks();
        t_sleep();
        t_irq();
        t_trig();
        t_rst();
        results();
    end
endmodule
